// ===== bench/tb_dbg_uart.sv
// Register-level testbench of the debug UART with a serial terminal
`default_nettype none
module tb_dbg_uart;
	import dbg_uart_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] RXRST = 32'h1 << CMD_RX_RESET;
	localparam logic [31:0] TXRST = 32'h1 << CMD_TX_RESET;
	localparam logic [31:0] RXON = 32'h1 << CMD_RX_ON;
	localparam logic [31:0] RXOFF = 32'h1 << CMD_RX_OFF;
	localparam logic [31:0] TXON = 32'h1 << CMD_TX_ON;
	localparam logic [31:0] TXOFF = 32'h1 << CMD_TX_OFF;
	localparam logic [31:0] CLRE = 32'h1 << CMD_CLR_ERR;
	// Parity bit of 0x5b for codes even, odd, forced zero, forced one
	localparam logic [3:0] EXP_PARITY = 4'b1001;
	logic clk = 0;
	logic rst = 1;
	logic rd = 0;
	logic wr = 0;
	logic parity_on = 0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic [31:0] r;
	logic [5:0] ext = 6'h00;
	logic waitreq, sin, sout, irq;
	int n_mismatch = 0;
	int num_checks = 0;
	int base, lows;
	int ext_bit[6] = '{F_RX_DMA_DONE, F_TX_DMA_DONE, F_TX_BUF_EMPTY,
		F_RX_BUF_FULL, F_DBG_WR, F_DBG_RD};

	dbg_uart dbg_uart_i (.i_ref_clk(clk), .i_reset(rst),
		.i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
		.i_avs_writedata(wdata), .i_avs_byteenable(4'hf),
		.o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
		.i_serial_in_pin(sin), .o_serial_out_pin(sout),
		.i_rx_dma_done(ext[0]), .i_tx_dma_done(ext[1]),
		.i_tx_dma_buffer_empty(ext[2]), .i_rx_dma_buffer_full(ext[3]),
		.i_dbg_chan_write_pending(ext[4]),
		.i_dbg_chan_read_pending(ext[5]), .o_irq(irq));
	uart_term_model uart_term_model_i (.i_clk(clk), .i_line(sout),
		.i_parity_on(parity_on), .o_line(sin));

	// 20 MHz reference clock
	initial begin
		forever #25 clk = ~clk;
	end
	//////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// Hold the request until waitrequest is sampled low, then release
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		addr <= a;
		wdata <= d;
		rd <= !w;
		wr <= w;
		do begin
			@(posedge clk);
			n++;
		end while (waitreq !== 1'b0 && n < 50);
		if (n >= 50) n_mismatch++;
		r = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus

	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wreg

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(r, e);
	endtask : rdchk

	task automatic flag(input int b, input logic v);
		bus(1'b0, OFF_FLAGS, 32'h0);
		chk({31'h0, r[b]}, {31'h0, v});
	endtask : flag

	// Bounded wait for the terminal to decode frame number n
	task automatic wait_rx(input int n);
		for (int i = 0; i < 3000 && uart_term_model_i.rx_cnt < n; i++)
			@(posedge clk);
		chk(32'(uart_term_model_i.rx_cnt), 32'(n));
	endtask : wait_rx
	//////////////////////////////////////////////////////////////////////
	// Watchdog sized well above the few thousand cycles the tests need
	initial begin
		#(60000 * 50);
		n_mismatch++;
		tally_and_finish();
	end

	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		// Reset values, write-only and unmapped places read zero
		rdchk(OFF_CONFIG, 32'h0);
		rdchk(OFF_IRQ_VIEW, 32'h0);
		rdchk(OFF_BAUD, 32'h0);
		rdchk(OFF_RX_HOLD, 32'h0);
		rdchk(OFF_COMMAND, 32'h0);
		rdchk(8'h24, 32'h0);
		// Mask set and clear registers
		wreg(OFF_IRQ_SET, 32'hffff_ffff);
		rdchk(OFF_IRQ_VIEW, 32'hc000_1afb);
		wreg(OFF_IRQ_CLR, 32'h0000_00ff);
		rdchk(OFF_IRQ_VIEW, 32'hc000_1a00);
		wreg(OFF_IRQ_SET, 32'h0);
		rdchk(OFF_IRQ_VIEW, 32'hc000_1a00);
		wreg(OFF_IRQ_CLR, 32'hffff_ffff);
		rdchk(OFF_IRQ_VIEW, 32'h0);
		// Each direct status input alone, unmasked then masked
		for (int i = 0; i < 6; i++) begin
			ext <= 6'h1 << i;
			wreg(OFF_IRQ_SET, 32'h1 << ext_bit[i]);
			rdchk(OFF_FLAGS, 32'h1 << ext_bit[i]);
			chk({31'h0, irq}, 32'h1);
			wreg(OFF_IRQ_CLR, 32'hffff_ffff);
			@(posedge clk);
			chk({31'h0, irq}, 32'h0);
		end
		ext <= 6'h00;
		// Transmitter enable, disable priority and ready flags
		wreg(OFF_BAUD, 32'h1);
		rdchk(OFF_BAUD, 32'h1);
		flag(F_TX_FREE, 1'b0);
		wreg(OFF_COMMAND, TXON | TXOFF);
		flag(F_TX_FREE, 1'b0);
		wreg(OFF_COMMAND, TXON);
		flag(F_TX_FREE, 1'b1);
		flag(F_TX_DONE, 1'b1);
		// Every parity code; 0x5b has an odd count of ones
		for (int m = 0; m < 5; m++) begin
			wreg(OFF_CONFIG, 32'(m) << PAR_LSB);
			parity_on <= (m < 4);
			base = uart_term_model_i.rx_cnt;
			wreg(OFF_TX_HOLD, 32'h5b);
			wait_rx(base + 1);
			chk({24'h0, uart_term_model_i.rx_byte}, 32'h5b);
			if (m < 4)
				chk({31'h0, uart_term_model_i.rx_parity}, {31'h0, EXP_PARITY[m]});
		end
		rdchk(OFF_CONFIG, 32'h800);
		// Two characters queued, then disable: both still go out
		base = uart_term_model_i.rx_cnt;
		wreg(OFF_TX_HOLD, 32'h11);
		wreg(OFF_TX_HOLD, 32'h22);
		flag(F_TX_FREE, 1'b0);
		flag(F_TX_DONE, 1'b0);
		wreg(OFF_COMMAND, TXOFF);
		wait_rx(base + 2);
		chk({24'h0, uart_term_model_i.rx_byte}, 32'h22);
		flag(F_TX_DONE, 1'b0);
		// Transmitter reset while a zero byte is on the line
		wreg(OFF_COMMAND, TXON);
		wreg(OFF_TX_HOLD, 32'h00);
		repeat (40) @(posedge clk);
		wreg(OFF_COMMAND, TXRST);
		repeat (2) @(posedge clk);
		chk({31'h0, sout}, 32'h1);
		repeat (200) @(posedge clk);
		// Reception and read-to-clear
		parity_on <= 1'b0;
		wreg(OFF_COMMAND, RXON);
		uart_term_model_i.send(8'h3c, 1'b0, 1'b0, 1'b1);
		flag(F_RX_WAIT, 1'b1);
		rdchk(OFF_RX_HOLD, 32'h3c);
		flag(F_RX_WAIT, 1'b0);
		// Bad parity, then bad stop with the first still unread
		wreg(OFF_CONFIG, 32'h0);
		uart_term_model_i.send(8'h01, 1'b1, 1'b0, 1'b1);
		uart_term_model_i.send(8'h02, 1'b1, 1'b1, 1'b0);
		repeat (20) @(posedge clk);
		rdchk(OFF_FLAGS, 32'h0000_00e1);
		bus(1'b0, OFF_RX_HOLD, 32'h0);
		uart_term_model_i.send(8'h03, 1'b1, 1'b0, 1'b1);
		rdchk(OFF_FLAGS, 32'h0000_00e1);
		wreg(OFF_COMMAND, CLRE);
		rdchk(OFF_FLAGS, 32'h0000_0001);
		wreg(OFF_COMMAND, RXOFF);
		flag(F_RX_WAIT, 1'b0);
		// Enable and disable together leave the receiver off
		wreg(OFF_CONFIG, 32'h800);
		bus(1'b0, OFF_RX_HOLD, 32'h0);
		wreg(OFF_COMMAND, RXON | RXOFF);
		uart_term_model_i.send(8'h44, 1'b0, 1'b0, 1'b1);
		wreg(OFF_COMMAND, RXON);
		flag(F_RX_WAIT, 1'b0);
		// Receiver reset mid-character; all-ones byte cannot restart
		fork
			uart_term_model_i.send(8'hff, 1'b0, 1'b0, 1'b1);
			begin
				repeat (40) @(posedge clk);
				wreg(OFF_COMMAND, RXRST);
				wreg(OFF_COMMAND, RXON);
			end
		join
		flag(F_RX_WAIT, 1'b0);
		// Disable mid-character still completes it
		fork
			uart_term_model_i.send(8'h55, 1'b0, 1'b0, 1'b1);
			begin
				repeat (40) @(posedge clk);
				wreg(OFF_COMMAND, RXOFF);
			end
		join
		wreg(OFF_COMMAND, RXON);
		flag(F_RX_WAIT, 1'b1);
		rdchk(OFF_RX_HOLD, 32'h55);
		// Local loopback: pin stays high, character returns inside
		wreg(OFF_CONFIG, 32'h0000_8800);
		wreg(OFF_COMMAND, TXON);
		wreg(OFF_TX_HOLD, 32'h5a);
		lows = 0;
		repeat (300) begin
			@(posedge clk);
			lows += 32'(!sout);
		end
		chk(32'(lows), 32'h0);
		rdchk(OFF_RX_HOLD, 32'h5a);
		// Automatic echo returns the terminal's own frame
		wreg(OFF_CONFIG, 32'h0000_4800);
		base = uart_term_model_i.rx_cnt;
		uart_term_model_i.send(8'h96, 1'b0, 1'b0, 1'b1);
		wait_rx(base + 1);
		chk({24'h0, uart_term_model_i.rx_byte}, 32'h96);
		rdchk(OFF_RX_HOLD, 32'h96);
		// Remote loopback: pin to pin, the receiver stays out of it
		wreg(OFF_CONFIG, 32'h0000_c800);
		base = uart_term_model_i.rx_cnt;
		uart_term_model_i.send(8'h69, 1'b0, 1'b0, 1'b1);
		wait_rx(base + 1);
		chk({24'h0, uart_term_model_i.rx_byte}, 32'h69);
		flag(F_RX_WAIT, 1'b0);
		tally_and_finish();
	end
endmodule : tb_dbg_uart
`default_nettype wire

// ===== bench/uart_term_model.sv
// Serial terminal model that sends and decodes frames on the debug line
`default_nettype none
module uart_term_model (
	// Clock and line
	input wire logic i_clk,
	input wire logic i_line,
	input wire logic i_parity_on,
	output logic o_line
);
	timeunit 1ns;
	timeprecision 1ns;
	int rx_cnt = 0;
	logic [7:0] rx_byte = 8'h00;
	logic rx_parity = 1'b0;
	// Line idles high like a pulled-up wire
	initial o_line = 1'b1;
	//////////////////////////////////////////////////////////////////////
	// One frame at sixteen clocks a bit; the eleventh slot is idle if
	// no parity bit is sent, so back-to-back sends keep a clean stop
	task automatic send(input logic [7:0] d, input logic p_on,
		input logic p, input logic stop);
		logic [10:0] f;
		f = p_on ? {stop, p, d, 1'b0} : {1'b1, stop, d, 1'b0};
		for (int i = 0; i < 11; i++) begin
			@(posedge i_clk);
			o_line <= f[i];
			repeat (15) @(posedge i_clk);
		end
		// Back to idle, so a bad stop bit does not hold the line low
		o_line <= 1'b1;
	endtask : send
	//////////////////////////////////////////////////////////////////////
	// Decode mid-bit from the falling start edge, LSB first
	always begin
		@(negedge i_line);
		repeat (8) @(posedge i_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (16) @(posedge i_clk);
			rx_byte[i] = i_line;
		end
		if (i_parity_on) begin
			repeat (16) @(posedge i_clk);
			rx_parity = i_line;
		end
		repeat (16) @(posedge i_clk);
		rx_cnt++;
	end
endmodule : uart_term_model
`default_nettype wire

// ===== src/dbg_uart.sv
// Debug UART with Avalon-MM register slave
`default_nettype none
// Operation
// - Receiver reset command disables receiver and aborts any character at once.
// - Transmitter reset command disables transmitter and aborts any character at once.
// - Receiver enable works only when receiver disable is zero in that write.
// - Receiver disable lets a character in progress finish before stopping.
// - Transmitter enable works only when transmitter disable is zero in that write.
// - Transmitter disable sends the shifting and waiting characters before stopping.
// - Error clear command clears parity, framing and overrun flags.
// - Parity select: even, odd, forced zero, forced one; top bit means none.
// - Ones written to interrupt enable set matching mask bits.
// - Ones written to interrupt disable clear matching mask bits.
// - Mask view shows enabled sources, resets to zero, status bit layout.
// - Receive-ready flag shows an unread character, zero when receiver disabled.
// - Transmit-ready flag zero while holding register full or transmitter disabled.
// - Transmitter-empty flag one only when holding and shifter empty and enabled.
// - Overrun, framing and parity flags stay set until error clear.
// - Flags 3 and 4 mirror receive and transmit DMA end signals.
// - Flag 11 mirrors transmit DMA buffer-empty signal.
// - Flag 12 mirrors receive DMA buffer-full signal.
// - Flags 30 and 31 mirror debug-channel write and read pending.
// - Reading the receive holding register clears receive-ready.
// - A character completing while receive-ready is set raises overrun, unless the receive holding register is read in that same cycle.
// - Local loopback feeds transmitter to receiver, ignores input, holds output high.
// - Receiver samples each bit sixteen baud ticks after the previous one.
module dbg_uart
	import dbg_uart_pkg::*;
#(
	parameter logic [31:0] CHIP_ID = 32'h0000_0000, // Arbitrary value
	parameter logic [31:0] CHIP_EXT = 32'h0000_0000 // Arbitrary value
) (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_reset,
	// Avalon-MM slave
	input wire logic [ADDR_W-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// Serial line
	input wire logic i_serial_in_pin,
	output logic o_serial_out_pin,
	// DMA channel and debug channel status
	input wire logic i_rx_dma_done,
	input wire logic i_tx_dma_done,
	input wire logic i_tx_dma_buffer_empty,
	input wire logic i_rx_dma_buffer_full,
	input wire logic i_dbg_chan_write_pending,
	input wire logic i_dbg_chan_read_pending,
	// Interrupt
	output logic o_irq
);

	////////////////////////////////////////////////////////////////////
	// Bus slave: every access waits one cycle, so read data are flopped
	logic ack_r;
	logic [31:0] rdata_r;
	logic [31:0] config_r;
	logic [31:0] mask_r;
	logic [15:0] baud_r;
	logic [7:0] rx_hold_r;
	logic [31:0] flags;
	logic [31:0] rd_mux;
	wire req = i_avs_read | i_avs_write;
	wire wr_acc = i_avs_write & ack_r;
	wire rd_acc = i_avs_read & ack_r;
	wire [31:0] be_mask = {{8{i_avs_byteenable[3]}},
		{8{i_avs_byteenable[2]}}, {8{i_avs_byteenable[1]}},
		{8{i_avs_byteenable[0]}}};
	wire [31:0] wdata = i_avs_writedata & be_mask;

	// Register decode
	wire wr_cmd = wr_acc && (i_avs_address == OFF_COMMAND);
	wire wr_cfg = wr_acc && (i_avs_address == OFF_CONFIG);
	wire wr_set = wr_acc && (i_avs_address == OFF_IRQ_SET);
	wire wr_clr = wr_acc && (i_avs_address == OFF_IRQ_CLR);
	wire wr_thr = wr_acc && (i_avs_address == OFF_TX_HOLD);
	wire wr_baud = wr_acc && (i_avs_address == OFF_BAUD);
	wire rd_rhr = rd_acc && (i_avs_address == OFF_RX_HOLD);

	// Command strobes
	wire rx_rst_cmd = wr_cmd & wdata[CMD_RX_RESET];
	wire tx_rst_cmd = wr_cmd & wdata[CMD_TX_RESET];
	wire rx_on_ok = wr_cmd & wdata[CMD_RX_ON] & ~wdata[CMD_RX_OFF];
	wire rx_off = wr_cmd & wdata[CMD_RX_OFF];
	wire tx_on_ok = wr_cmd & wdata[CMD_TX_ON] & ~wdata[CMD_TX_OFF];
	wire tx_off = wr_cmd & wdata[CMD_TX_OFF];
	wire clr_err = wr_cmd & wdata[CMD_CLR_ERR];

	// Config fields
	wire [2:0] parity_select = config_r[PAR_LSB+:3];
	wire [1:0] channel_select = config_r[CHAN_LSB+:2];
	wire par_on = ~parity_select[2];

	// Read mux; unmapped and write-only offsets read as zero
	always_comb begin
		case (i_avs_address)
			OFF_CONFIG: rd_mux = config_r;
			OFF_IRQ_VIEW: rd_mux = mask_r;
			OFF_FLAGS: rd_mux = flags;
			OFF_RX_HOLD: rd_mux = {24'h000000, rx_hold_r};
			OFF_BAUD: rd_mux = {16'h0000, baud_r};
			OFF_CHIP_ID: rd_mux = CHIP_ID;
			OFF_CHIP_EXT: rd_mux = CHIP_EXT;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Handshake: wait state in the first cycle, accept in the second
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			ack_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
		end else begin
			ack_r <= req & ~ack_r;
			rdata_r <= rd_mux;
		end
	end
	assign o_avs_waitrequest = req & ~ack_r;
	assign o_avs_readdata = rdata_r;

	// Config, baud and interrupt mask registers
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			config_r <= CONFIG_RST;
			baud_r <= BAUD_RST;
			mask_r <= MASK_RST;
		end else begin
			if (wr_cfg)
				config_r <= wdata & CONFIG_WMASK;
			if (wr_baud)
				baud_r <= wdata[15:0];
			if (wr_set)
				mask_r <= mask_r | (wdata & IRQ_VALID);
			else if (wr_clr)
				mask_r <= mask_r & ~wdata;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Baud tick: divisor 0 stops it, 1 ticks every clock
	logic [15:0] div_r;
	wire tick = (baud_r != 16'h0000) && (div_r == 16'(baud_r - 16'h1));
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset)
			div_r <= 16'h0000;
		else if (tick || baud_r == 16'h0000)
			div_r <= 16'h0000;
		else
			div_r <= 16'(div_r + 16'h1);
	end

	// Parity bit for a character under the selected mode
	function automatic logic par_calc(input logic [1:0] p,
		input logic [7:0] d);
		case (p)
			PAR_EVEN: par_calc = ^d;
			PAR_ODD: par_calc = ~^d;
			PAR_SPACE: par_calc = 1'b0;
			default: par_calc = 1'b1;
		endcase
	endfunction : par_calc

	////////////////////////////////////////////////////////////////////
	// Transmitter
	ser_state_e tx_state;
	logic tx_en_r;
	logic tx_stop_r;
	logic thr_full_r;
	logic [7:0] thr_r;
	logic [7:0] tx_sh_r;
	logic [3:0] tx_cnt_r;
	logic [2:0] tx_bit_r;
	logic tx_pbit_r;
	logic tx_line;
	// Remote loopback keeps the transmitter off the line and idle
	wire tx_go = tx_en_r && (channel_select != CH_REMOTE);
	wire tx_idle = (tx_state == S_IDLE);
	wire tx_bit_end = tick && (tx_cnt_r == TICK_LAST);

	always_comb begin
		case (tx_state)
			S_START: tx_line = 1'b0;
			S_DATA: tx_line = tx_sh_r[0];
			S_PAR: tx_line = tx_pbit_r;
			default: tx_line = 1'b1;
		endcase
	end

	// Holding register; writes while disabled are dropped
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			thr_full_r <= 1'b0;
			thr_r <= 8'h00;
		end else if (tx_rst_cmd) begin
			thr_full_r <= 1'b0;
		end else if (wr_thr && tx_en_r && !tx_stop_r) begin
			thr_full_r <= 1'b1;
			thr_r <= wdata[7:0];
		end else if (tx_go && tx_idle) begin
			thr_full_r <= 1'b0;
		end
	end

	// Transmit state machine and enable control
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			tx_state <= S_IDLE;
			tx_en_r <= 1'b0;
			tx_stop_r <= 1'b0;
			tx_sh_r <= 8'h00;
			tx_cnt_r <= 4'h0;
			tx_bit_r <= 3'h0;
			tx_pbit_r <= 1'b0;
		end else if (tx_rst_cmd) begin
			tx_state <= S_IDLE;
			tx_en_r <= 1'b0;
			tx_stop_r <= 1'b0;
		end else begin
			if (tx_on_ok) begin
				tx_en_r <= 1'b1;
				tx_stop_r <= 1'b0;
			end else if (tx_off) begin
				tx_stop_r <= 1'b1;
			end else if (tx_stop_r && tx_idle && !thr_full_r) begin
				tx_en_r <= 1'b0;
				tx_stop_r <= 1'b0;
			end
			case (tx_state)
				S_IDLE: begin
					if (tx_go && thr_full_r) begin
						tx_sh_r <= thr_r;
						tx_pbit_r <= par_calc(parity_select[1:0], thr_r);
						tx_cnt_r <= 4'h0;
						tx_state <= S_START;
					end
				end
				S_START, S_PAR, S_STOP: begin
					if (tick)
						tx_cnt_r <= 4'(tx_cnt_r + 4'h1);
					if (tx_bit_end) begin
						tx_bit_r <= 3'h0;
						if (tx_state == S_START)
							tx_state <= S_DATA;
						else if (tx_state == S_PAR)
							tx_state <= S_STOP;
						else
							tx_state <= S_IDLE;
					end
				end
				S_DATA: begin
					if (tick)
						tx_cnt_r <= 4'(tx_cnt_r + 4'h1);
					if (tx_bit_end) begin
						tx_sh_r <= {1'b0, tx_sh_r[7:1]};
						tx_bit_r <= 3'(tx_bit_r + 3'h1);
						if (tx_bit_r == BIT_LAST)
							tx_state <= par_on ? S_PAR : S_STOP;
					end
				end
				default: tx_state <= S_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Line routing per channel mode; output flopped for a clean pin
	logic out_r;
	wire rx_line = (channel_select == CH_LOCAL) ?
		tx_line : i_serial_in_pin;
	wire out_nxt = (channel_select == CH_NORMAL) ? tx_line :
		(channel_select == CH_LOCAL) ? 1'b1 : i_serial_in_pin;
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset)
			out_r <= 1'b1;
		else
			out_r <= out_nxt;
	end
	assign o_serial_out_pin = out_r;

	////////////////////////////////////////////////////////////////////
	// Receiver
	ser_state_e rx_state;
	logic rx_en_r;
	logic rx_stop_r;
	logic [7:0] rx_sh_r;
	logic [3:0] rx_cnt_r;
	logic [2:0] rx_bit_r;
	logic rx_par_r;
	logic rx_wait_r;
	logic overrun_r;
	logic frame_r;
	logic par_err_r;
	wire rx_idle = (rx_state == S_IDLE);
	wire rx_go = rx_en_r && !rx_stop_r && (channel_select != CH_REMOTE);
	wire rx_bit_end = tick && (rx_cnt_r == TICK_LAST);
	wire rx_done = (rx_state == S_STOP) && rx_bit_end && !rx_rst_cmd;

	// Receive state machine and enable control
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			rx_state <= S_IDLE;
			rx_en_r <= 1'b0;
			rx_stop_r <= 1'b0;
			rx_sh_r <= 8'h00;
			rx_cnt_r <= 4'h0;
			rx_bit_r <= 3'h0;
			rx_par_r <= 1'b0;
		end else if (rx_rst_cmd) begin
			rx_state <= S_IDLE;
			rx_en_r <= 1'b0;
			rx_stop_r <= 1'b0;
		end else begin
			if (rx_on_ok) begin
				rx_en_r <= 1'b1;
				rx_stop_r <= 1'b0;
			end else if (rx_off) begin
				rx_stop_r <= 1'b1;
			end else if (rx_stop_r && rx_idle) begin
				rx_en_r <= 1'b0;
				rx_stop_r <= 1'b0;
			end
			case (rx_state)
				S_IDLE: begin
					if (rx_go && !rx_line) begin
						rx_cnt_r <= 4'h0;
						rx_state <= S_START;
					end
				end
				S_START: begin
					// Recheck mid start bit to reject glitches
					if (tick)
						rx_cnt_r <= 4'(rx_cnt_r + 4'h1);
					if (tick && rx_cnt_r == TICK_MID) begin
						rx_cnt_r <= 4'h0;
						rx_bit_r <= 3'h0;
						rx_state <= rx_line ? S_IDLE : S_DATA;
					end
				end
				S_DATA: begin
					if (tick)
						rx_cnt_r <= 4'(rx_cnt_r + 4'h1);
					if (rx_bit_end) begin
						rx_sh_r <= {rx_line, rx_sh_r[7:1]};
						rx_bit_r <= 3'(rx_bit_r + 3'h1);
						if (rx_bit_r == BIT_LAST)
							rx_state <= par_on ? S_PAR : S_STOP;
					end
				end
				S_PAR: begin
					if (tick)
						rx_cnt_r <= 4'(rx_cnt_r + 4'h1);
					if (rx_bit_end) begin
						rx_par_r <= rx_line;
						rx_state <= S_STOP;
					end
				end
				S_STOP: begin
					if (tick)
						rx_cnt_r <= 4'(rx_cnt_r + 4'h1);
					if (rx_bit_end)
						rx_state <= S_IDLE;
				end
				default: rx_state <= S_IDLE;
			endcase
		end
	end

	// Receive flags; a new event wins over a clear in the same cycle
	wire ovr_set = rx_done & rx_wait_r & ~rd_rhr;
	wire frm_set = rx_done & ~rx_line;
	wire par_set = rx_done & par_on &
		(rx_par_r != par_calc(parity_select[1:0], rx_sh_r));
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			rx_wait_r <= 1'b0;
			rx_hold_r <= RX_HOLD_RST;
			overrun_r <= 1'b0;
			frame_r <= 1'b0;
			par_err_r <= 1'b0;
		end else begin
			if (rx_done)
				rx_hold_r <= rx_sh_r;
			if (rx_rst_cmd)
				rx_wait_r <= 1'b0;
			else
				rx_wait_r <= (rx_wait_r & ~rd_rhr) | rx_done;
			overrun_r <= (overrun_r & ~clr_err) | ovr_set;
			frame_r <= (frame_r & ~clr_err) | frm_set;
			par_err_r <= (par_err_r & ~clr_err) | par_set;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Status word and interrupt
	always_comb begin
		flags = 32'h0000_0000;
		flags[F_RX_WAIT] = rx_wait_r & rx_en_r;
		flags[F_TX_FREE] = tx_en_r & ~thr_full_r;
		flags[F_RX_DMA_DONE] = i_rx_dma_done;
		flags[F_TX_DMA_DONE] = i_tx_dma_done;
		flags[F_OVERRUN] = overrun_r;
		flags[F_FRAME] = frame_r;
		flags[F_PARITY] = par_err_r;
		flags[F_TX_DONE] = tx_en_r & ~thr_full_r & tx_idle;
		flags[F_TX_BUF_EMPTY] = i_tx_dma_buffer_empty;
		flags[F_RX_BUF_FULL] = i_rx_dma_buffer_full;
		flags[F_DBG_WR] = i_dbg_chan_write_pending;
		flags[F_DBG_RD] = i_dbg_chan_read_pending;
	end
	assign o_irq = |(flags & mask_r);

	////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_reset);

	rx_reset_abort_a: assert property (
		rx_rst_cmd |=> !rx_en_r && rx_idle && !flags[F_RX_WAIT])
		else $error("receiver reset did not abort");
	tx_reset_abort_a: assert property (
		tx_rst_cmd |=> !tx_en_r && tx_idle && !thr_full_r)
		else $error("transmitter reset did not abort");
	rx_off_wins_a: assert property (
		wr_cmd && wdata[CMD_RX_ON] && wdata[CMD_RX_OFF] && !rx_en_r
		&& !wdata[CMD_RX_RESET] |=> !rx_en_r)
		else $error("receiver enabled despite disable");
	rx_off_finish_a: assert property (
		rx_off && !rx_rst_cmd && !rx_idle && rx_en_r |=> rx_en_r)
		else $error("receiver stopped mid character");
	tx_off_drain_a: assert property (
		tx_en_r && thr_full_r && !tx_rst_cmd |=> tx_en_r)
		else $error("transmitter stopped with data held");
	err_clear_a: assert property (
		clr_err && !rx_done |=> !overrun_r && !frame_r && !par_err_r)
		else $error("error flags not cleared");
	mask_set_a: assert property (
		wr_set |=> mask_r == ($past(mask_r) | $past(wdata & IRQ_VALID)))
		else $error("mask set wrong");
	mask_clear_a: assert property (
		wr_clr |=> (mask_r & $past(wdata)) == 32'h0000_0000)
		else $error("mask clear wrong");
	rhr_read_clear_a: assert property (
		rd_rhr && !rx_done |=> !flags[F_RX_WAIT])
		else $error("receive flag not cleared by read");
	overrun_set_a: assert property (
		rx_done && rx_wait_r && !rd_rhr |=> overrun_r)
		else $error("overrun missed");
	local_idle_a: assert property (
		channel_select == CH_LOCAL |=> o_serial_out_pin)
		else $error("loopback line not idle");
	thr_write_busy_a: assert property (
		wr_thr && tx_en_r && !tx_stop_r && !tx_rst_cmd
		|=> !flags[F_TX_FREE] || $past(tx_go && tx_idle))
		else $error("transmit ready after write");

endmodule : dbg_uart
`default_nettype wire

// ===== src/dbg_uart_pkg.sv
// Register map, field positions and timing constants of the debug UART
`default_nettype none
package dbg_uart_pkg;
	// Byte offsets on the register bus
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_COMMAND = 8'h00;
	localparam logic [7:0] OFF_CONFIG = 8'h04;
	localparam logic [7:0] OFF_IRQ_SET = 8'h08;
	localparam logic [7:0] OFF_IRQ_CLR = 8'h0c;
	localparam logic [7:0] OFF_IRQ_VIEW = 8'h10;
	localparam logic [7:0] OFF_FLAGS = 8'h14;
	localparam logic [7:0] OFF_RX_HOLD = 8'h18;
	localparam logic [7:0] OFF_TX_HOLD = 8'h1c;
	localparam logic [7:0] OFF_BAUD = 8'h20;
	localparam logic [7:0] OFF_CHIP_ID = 8'h40;
	localparam logic [7:0] OFF_CHIP_EXT = 8'h44;
	// Command bits
	localparam int CMD_RX_RESET = 2;
	localparam int CMD_TX_RESET = 3;
	localparam int CMD_RX_ON = 4;
	localparam int CMD_RX_OFF = 5;
	localparam int CMD_TX_ON = 6;
	localparam int CMD_TX_OFF = 7;
	localparam int CMD_CLR_ERR = 8;
	// Config fields
	localparam int PAR_LSB = 9;
	localparam int CHAN_LSB = 14;
	localparam logic [31:0] CONFIG_WMASK = 32'h0000_ce00;
	// Flag bit positions, shared by the mask register
	localparam int F_RX_WAIT = 0;
	localparam int F_TX_FREE = 1;
	localparam int F_RX_DMA_DONE = 3;
	localparam int F_TX_DMA_DONE = 4;
	localparam int F_OVERRUN = 5;
	localparam int F_FRAME = 6;
	localparam int F_PARITY = 7;
	localparam int F_TX_DONE = 9;
	localparam int F_TX_BUF_EMPTY = 11;
	localparam int F_RX_BUF_FULL = 12;
	localparam int F_DBG_WR = 30;
	localparam int F_DBG_RD = 31;
	localparam logic [31:0] IRQ_VALID = 32'hc000_1afb;
	// Reset values
	localparam logic [31:0] CONFIG_RST = 32'h0000_0000;
	localparam logic [31:0] MASK_RST = 32'h0000_0000;
	localparam logic [15:0] BAUD_RST = 16'h0000;
	localparam logic [7:0] RX_HOLD_RST = 8'h00;
	// Channel modes
	localparam logic [1:0] CH_NORMAL = 2'h0;
	localparam logic [1:0] CH_ECHO = 2'h1;
	localparam logic [1:0] CH_LOCAL = 2'h2;
	localparam logic [1:0] CH_REMOTE = 2'h3;
	// Parity low bits when the top bit is clear
	localparam logic [1:0] PAR_EVEN = 2'h0;
	localparam logic [1:0] PAR_ODD = 2'h1;
	localparam logic [1:0] PAR_SPACE = 2'h2;
	// Bit timing in baud ticks
	localparam logic [3:0] TICK_LAST = 4'hf;
	localparam logic [3:0] TICK_MID = 4'h7;
	localparam logic [2:0] BIT_LAST = 3'h7;
	// Serial state machine states, one-hot
	typedef enum logic [4:0] {
		S_IDLE = 5'h01,
		S_START = 5'h02,
		S_DATA = 5'h04,
		S_PAR = 5'h08,
		S_STOP = 5'h10
	} ser_state_e;
endpackage : dbg_uart_pkg
`default_nettype wire
